// ### design/sac_top.sv
/*
  conversion control and serial result readout for a 20-bit converter.
  assumes the host drives convert_start, serial_clk and serial_in as pins; they are
  sampled by core_clk. results come from a conversion core on result_valid/result_data.
*/
// Behaviour
// [RL1] result available 300 to 350 ns after convert_start rises, nominally 320 ns
// [RL2] acquisition phase of at least 325, 770 or 1770 ns per variant
// [RL3] host uses fastest rate only with fast readout and a fast serial clock
// [RL4] host waits 200 ns after convert_start before first serial clock rise
// [RL5] host leaves 60 ns from last serial clock fall to convert_start rise
// [RL6] chip-select mode: host holds convert_start high at least 10 ns
// [RL7] chip-select mode: drive result msb when convert_start or serial_in goes low
// [RL8] next bit presented after serial clock fall; previous bit held briefly; daisy-chain mode presents the next bit after the rise instead
// [RL9] chip-select mode: release output on convert_start/serial_in high or last fall
// [RL10] serial_in level sampled at the rising edge of convert_start
// [RL11] daisy-chain mode: serial_in captured on serial clock rising edges
// [RL12] 20-bit two's complement result, msb first, no pipeline latency
`timescale 1ns/1ps
module sac_top
  import sac_pkg::*;
#(
  parameter int VARIANT = 0  // 0 fast, 1 mid, 2 slow acquisition minimum
) (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_b,
  // host pins
  input  wire logic                         convert_start,
  input  wire logic                         serial_clk,
  input  wire logic                         serial_in,
  output logic                              serial_out,
  output logic                              serial_out_oe,
  // wiring mode: 0 chip-select, 1 daisy-chain
  input  wire logic                         daisy_mode,
  // conversion core result
  input  wire logic                         result_valid,
  output logic                              result_ready,
  input  wire logic [sac_pkg::RESULT_W-1:0] result_data,
  // status
  output logic                              converting,
  output logic                              acq_ready,
  output logic                              sampled_sel
);
  localparam int ACQ_CYCLES = (VARIANT == 0) ? ACQ_FAST_CYCLES :
                              (VARIANT == 1) ? ACQ_MID_CYCLES : ACQ_SLOW_CYCLES;

  sac_state_e            state;
  logic [CNT_W-1:0]      conv_cnt;
  logic [CNT_W-1:0]      acq_cnt;
  logic [2:0]            cnv_sync;
  logic [2:0]            sck_sync;
  logic [2:0]            sdi_sync;
  logic                  cnv_rise;
  logic                  cnv_fall;
  logic                  sck_rise;
  logic                  sck_fall;
  logic                  sdi_fall;
  logic                  sdi_rise;
  logic [RESULT_W-1:0]   shift;
  logic [4:0]            bits_left;
  logic                  f_valid;
  logic                  f_ready;
  logic [RESULT_W-1:0]   f_data;
  logic                  load;
  logic                  conv_end;
  logic [RESULT_W-1:0]   last_word;

  // two flip-flop synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cnv_sync <= '0;
      sck_sync <= '0;
      sdi_sync <= '1;  // serial_in idles high, so no false edge after reset
    end
    else
    begin
      cnv_sync <= {cnv_sync[1:0], convert_start};
      sck_sync <= {sck_sync[1:0], serial_clk};
      sdi_sync <= {sdi_sync[1:0], serial_in};
    end
  end

  // edge detection on the synchronised levels
  assign cnv_rise = cnv_sync[1] & ~cnv_sync[2];
  assign cnv_fall = ~cnv_sync[1] & cnv_sync[2];
  assign sck_rise = sck_sync[1] & ~sck_sync[2];
  assign sck_fall = ~sck_sync[1] & sck_sync[2];
  assign sdi_fall = ~sdi_sync[1] & sdi_sync[2];
  assign sdi_rise = sdi_sync[1] & ~sdi_sync[2];

  // result buffer between conversion core and shifter
  sac_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .in_valid  (result_valid),
    .in_ready  (f_ready),
    .in_data   (result_data),
    .out_valid (f_valid),
    .out_ready (load),
    .out_data  (f_data)
  );

  // conversion sequencer: acquisition, conversion, result ready
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state    <= SAC_ACQ;
      conv_cnt <= '0;
    end
    else
    begin
      case (state)
        SAC_ACQ, SAC_DONE:
        begin
          if (cnv_rise)
          begin
            state    <= SAC_CONV;
            conv_cnt <= '0;
          end
        end
        SAC_CONV:
        begin
          conv_cnt <= conv_cnt + 1'b1;
          if (conv_end)  // see [RL1]
          begin
            state <= SAC_DONE;
          end
        end
        default:
        begin
          state <= SAC_ACQ;
        end
      endcase
    end
  end

  // acquisition timer, restarted at the end of each conversion
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      acq_cnt   <= CNT_W'(ACQ_CYCLES);  // start saturated so acq_ready stays high
      acq_ready <= 1'b1;
    end
    else if (state == SAC_CONV)
    begin
      acq_cnt   <= '0;
      acq_ready <= 1'b0;
    end
    else if (acq_cnt != CNT_W'(ACQ_CYCLES))  // see [RL2]
    begin
      acq_cnt   <= acq_cnt + 1'b1;
      acq_ready <= (acq_cnt == CNT_W'(ACQ_CYCLES - 1));
    end
  end

  // status outputs
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      converting   <= 1'b0;
      result_ready <= 1'b0;
    end
    else
    begin
      converting   <= (state == SAC_CONV);
      result_ready <= f_ready;
    end
  end

  // serial_in level caught at the convert_start rise, reported on sampled_sel only
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sampled_sel <= 1'b0;
    end
    else if (cnv_rise)
    begin
      sampled_sel <= sdi_sync[1];  // see [RL10]
    end
  end

  // conversion ends once the synchroniser delay is taken off the conversion time
  assign conv_end = (state == SAC_CONV) && (conv_cnt == CNT_W'(CONV_RUN_CYCLES - 1));  // see [RL1]
  // pop the oldest result from the fifo as conversion ends
  assign load     = conv_end && f_valid;  // see [RL12]

  // word last popped, replayed when a conversion finds the fifo empty
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      last_word <= RESULT_RST;
    end
    else if (load)
    begin
      last_word <= f_data;
    end
  end

  // output shifter, msb first
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      shift     <= RESULT_RST;
      bits_left <= '0;
    end
    else if (conv_end)
    begin
      shift     <= f_valid ? f_data : last_word;  // see [RL12]
      bits_left <= 5'(RESULT_W);
    end
    else if (daisy_mode && sck_rise)
    begin
      shift <= {shift[RESULT_W-2:0], sdi_sync[1]};  // see [RL11]
    end
    else if (!daisy_mode && sck_fall && bits_left != '0)
    begin
      shift     <= {shift[RESULT_W-2:0], 1'b0};  // see [RL8]
      bits_left <= bits_left - 1'b1;
    end
  end

  // serial output drive and release
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end
    else
    begin
      serial_out <= shift[RESULT_W-1];  // see [RL8]
      if (daisy_mode)
      begin
        serial_out_oe <= 1'b1;
      end
      else if (cnv_rise || sdi_rise || (sck_fall && bits_left == 5'd1))
      begin
        serial_out_oe <= 1'b0;  // see [RL9]
      end
      else if ((cnv_fall || sdi_fall) && state == SAC_DONE)
      begin
        serial_out_oe <= 1'b1;  // see [RL7]
      end
    end
  end
endmodule : sac_top

// ### common/sac_pkg.sv
/*
  package for the converter control and serial readout block: timing constants,
  widths and state encodings.
  assumes a 20 MHz core clock.
*/
package sac_pkg;
  localparam int CLK_PERIOD_NS         = 50;
  localparam int RESULT_W              = 20;
  // conversion time, figures in ns
  localparam int CONV_TIME_MIN_NS      = 300;
  localparam int CONV_TIME_MAX_NS      = 350;
  localparam int CONV_TIME_NS          = 320;
  localparam int CONV_CYCLES           = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // the pin synchroniser and edge detector use up this many cycles of the conversion time
  localparam int SYNC_CYCLES           = 3;
  localparam int CONV_RUN_CYCLES       = CONV_CYCLES - SYNC_CYCLES;
  // acquisition phase minimum per variant, ns
  localparam int ACQ_FAST_NS           = 325;
  localparam int ACQ_MID_NS            = 770;
  localparam int ACQ_SLOW_NS           = 1770;
  localparam int ACQ_FAST_CYCLES       = (ACQ_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_MID_CYCLES        = (ACQ_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_SLOW_CYCLES       = (ACQ_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // host side quiet windows, kept for reference by the bench
  localparam int QUIET_AFTER_CONVERT_NS  = 200;
  localparam int QUIET_BEFORE_CONVERT_NS = 60;
  localparam int CONVERT_PULSE_WIDTH_NS  = 10;
  localparam int CNT_W                 = 6;
  localparam logic [RESULT_W-1:0] RESULT_RST = 20'h0_0000;
  localparam int FIFO_DEPTH            = 8;

  typedef enum logic [1:0]
  {
    SAC_ACQ  = 2'b00,
    SAC_CONV = 2'b01,
    SAC_DONE = 2'b11
  } sac_state_e;
endpackage : sac_pkg

// ### design/sac_fifo.sv
/*
  small synchronous fifo with valid and ready on both sides.
  assumes one clock and a synchronous active low reset.
*/
`timescale 1ns/1ps
module sac_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  // honest full and empty from the fill count
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // storage write
  always_ff @(posedge core_clk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : sac_fifo

// ### tb/sac_top_asserts.sv
/*
  checker for the readout pin timing of sac_top.
  assumes pins sampled by core_clk.
*/
`timescale 1ns/1ps
module sac_top_asserts
  import sac_pkg::*;
#(
  parameter int VARIANT = 0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // host pins
  input wire logic convert_start,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic daisy_mode,
  // status
  input wire logic converting,
  input wire logic acq_ready,
  input wire logic sampled_sel
);
  localparam int ACQ_N = VARIANT == 0 ? ACQ_FAST_CYCLES : VARIANT == 1 ? ACQ_MID_CYCLES : ACQ_SLOW_CYCLES;
  logic       sclk_q;
  logic       sclk_fall;
  logic [4:0] fall_cnt;
  logic [3:0] since_fall;
  logic [7:0] idle_cnt;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  assign sclk_fall = sclk_q & ~serial_clk;
  // falls per frame and cycles since the last fall
  always_ff @(posedge core_clk)
  begin
    sclk_q     <= serial_clk;
    fall_cnt   <= serial_out_oe ? fall_cnt + {4'h0, sclk_fall} : 5'h00;
    since_fall <= sclk_fall ? 4'h0 : (!rst_b || since_fall == 4'hf) ? 4'hf : since_fall + 4'h1;
  end
  // cycles since the conversion ended, saturating
  always_ff @(posedge core_clk)
  begin
    idle_cnt <= !rst_b ? 8'hff : converting ? 8'h00 : idle_cnt + {7'h0, idle_cnt != 8'hff};
  end
  a_conv_len: assert property ($rose(converting) |-> converting [*4] ##1 !converting)
    else $error("conversion length off");
  a_conv_start: assert property ($rose(convert_start) |-> ##[2:5] converting)
    else $error("conversion not started");
  a_acq_min: assert property ($rose(acq_ready) |-> idle_cnt >= ACQ_N - 1)
    else $error("acquisition too short");
  a_drive_msb: assert property ($fell(convert_start) && !daisy_mode && !converting
    |-> ##[1:5] serial_out_oe)
    else $error("output not enabled");
  a_bit_hold: assert property (!daisy_mode && serial_out_oe && $past(serial_out_oe, 2)
    && $changed(serial_out) |-> since_fall <= 4'h7)
    else $error("bit moved away from a fall");
  a_release_cnv: assert property (!daisy_mode && serial_out_oe && $rose(convert_start)
    |-> ##[1:5] !serial_out_oe)
    else $error("output kept on convert");
  a_release_end: assert property (!daisy_mode && serial_out_oe && fall_cnt == 5'h14
    |-> ##[0:5] !serial_out_oe)
    else $error("output kept after last bit");
  a_sel_sample: assert property ($rose(convert_start) |-> ##5 sampled_sel == $past(serial_in, 5))
    else $error("serial_in level lost");
  a_daisy_drive: assert property (daisy_mode [*2] |-> serial_out_oe)
    else $error("daisy output not driven");
  c_full_word: cover property (fall_cnt == 5'h14);
  c_abort: cover property (serial_out_oe && $rose(convert_start));
  c_acq: cover property ($rose(acq_ready));
  c_daisy: cover property (daisy_mode && $fell(converting));
endmodule : sac_top_asserts

bind sac_top sac_top_asserts #(.VARIANT(VARIANT)) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .convert_start(convert_start), .serial_clk(serial_clk),
  .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .daisy_mode(daisy_mode),
  .converting(converting), .acq_ready(acq_ready), .sampled_sel(sampled_sel)
);

// ### tb/sac_host.sv
/*
  host model: raises convert_start, clocks the result out.
  assumes chip-select wiring; serial clock idle low between frames.
*/
`timescale 1ns/1ps
module sac_host (
  // host driven pins
  output logic      convert_start,
  output logic      serial_clk,
  output logic      serial_in,
  // device driven pins
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  // pins idle at time zero
  initial
  begin
    convert_start = 1'b0;
    serial_clk = 1'b0;
    serial_in = 1'b1;
  end
  // one conversion, serial_in level held around the rise
  task automatic convert(input logic sel);
    serial_in = sel;
    #60;
    convert_start = 1'b1;
    #200;
    serial_in = 1'b1;
    #600;
  endtask : convert
  // 400 ns serial clock, far from full rate
  task automatic read(input int n, output logic [19:0] w);
    w = 20'h0_0000;
    convert_start = 1'b0;
    #200;
    repeat (n)
    begin
      serial_clk = 1'b1;
      #200;
      w = {w[18:0], serial_out_oe ? serial_out : ~w[0]};
      serial_clk = 1'b0;
      #200;
    end
  endtask : read
endmodule : sac_host

// ### tb/sac_top_bench.sv
/*
  bench for sac_top: fifo fill, conversions, readouts, an abort.
  assumes sac_host drives the pins in chip-select wiring, then in daisy-chain wiring for the last readout.
*/
`timescale 1ns/1ps
`define CHK(a, b) \
  begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module sac_top_bench;
  import sac_pkg::*;
  logic core_clk, rst_b, convert_start, serial_clk, serial_in, serial_out, serial_out_oe;
  logic daisy_mode, result_valid, result_ready, converting, acq_ready, sampled_sel, sel;
  logic [RESULT_W-1:0] result_data, got, want;
  logic [RESULT_W-1:0] exp_q[$];
  logic [31:0] seed = 32'h0001_484e;
  int errors = 0;
  int checks_done = 0;
  sac_top #(.VARIANT(0)) i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .convert_start(convert_start), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .daisy_mode(daisy_mode),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data),
    .converting(converting), .acq_ready(acq_ready), .sampled_sel(sampled_sel)
  );
  sac_host u_host (
    .convert_start(convert_start), .serial_clk(serial_clk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe)
  );
  // 50 ns core clock
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // word for fifo slot i: extremes first, then random
  function automatic logic [RESULT_W-1:0] word(input int i);
    logic [31:0] r;
    r = rnd();
    return i == 0 ? 20'h8_0000 : i == 1 ? 20'h7_ffff : r[RESULT_W-1:0];
  endfunction : word
  // verdict and end of run
  task automatic test_done();
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  // watchdog
  initial
  begin
    #300_000;
    errors++;
    test_done();
  end
  // reset, fill, then one readout per word and one on an empty fifo
  initial
  begin
    rst_b = 1'b0;
    daisy_mode = 1'b0;
    result_valid = 1'b0;
    result_data = 20'h0_0000;
    repeat (4) @(posedge core_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK(serial_out_oe, 1'b0)
    `CHK(acq_ready, 1'b1)
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      result_data = word(i);
      result_valid = 1'b1;
      exp_q.push_back(result_data);
      // result_ready just after the edge tells whether the fifo took the word
      @(posedge core_clk);
      #1;
      while (result_ready !== 1'b1)
      begin
        @(posedge core_clk);
        #1;
      end
    end
    result_valid = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(result_ready, 1'b0)
    for (int i = 0; i <= FIFO_DEPTH; i++)
    begin
      want = exp_q[(i < FIFO_DEPTH) ? i : FIFO_DEPTH - 1];
      sel = ^rnd();
      u_host.convert(sel);
      `CHK(sampled_sel, sel)
      `CHK(converting, 1'b0)
      `CHK(acq_ready, 1'b1)
      if (i == FIFO_DEPTH)
      begin
        u_host.read(7, got);
        `CHK(got[6:0], want[19:13])
        u_host.convert(1'b1);
        `CHK(serial_out_oe, 1'b0)
      end
      u_host.read(RESULT_W, got);
      `CHK(got, want)
      `CHK(serial_out_oe, 1'b0)
    end
    // daisy-chain readout: the msb is missed and the one held on serial_in follows the other 19 bits out
    @(posedge core_clk);
    #1;
    daisy_mode = 1'b1;
    result_data = word(FIFO_DEPTH);
    result_valid = 1'b1;
    want = result_data;
    @(posedge core_clk);
    #1;
    result_valid = 1'b0;
    `CHK(result_ready, 1'b1)
    `CHK(serial_out_oe, 1'b1)
    u_host.convert(1'b1);
    u_host.read(RESULT_W, got);
    `CHK(got, {want[RESULT_W-2:0], 1'b1})
    test_done();
  end
endmodule : sac_top_bench
